// file: verilog/swrs_pkg.sv
package swrs_pkg;
  // instruction opcodes (12 bit)
  localparam logic [11:0] SWRS_OP_SLEEP = 12'h003;
  localparam logic [11:0] SWRS_OP_CLEAR_WDOG = 12'h004;

  // register byte offsets
  localparam int SWRS_ADDR_W = 4;
  localparam logic [3:0] SWRS_OFS_STATUS = 4'h0;
  localparam logic [3:0] SWRS_OFS_CTRL = 4'h4;

  // status field positions
  localparam int SWRS_ST_SLEEP = 0;
  localparam int SWRS_ST_PWD = 3;
  localparam int SWRS_ST_TMO = 4;
  localparam int SWRS_ST_PCW = 7;

  // control field positions and reset value
  localparam int SWRS_CT_SWDT = 0;
  localparam int SWRS_CT_PCWEN = 1;
  localparam logic [1:0] SWRS_CTRL_RST = 2'h2;

  // pins of the second port that can wake the core
  localparam logic [7:0] SWRS_WAKE_MASK = 8'h8f;

  localparam logic [1:0] SWRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWRS_RESP_SLVERR = 2'h2;
  localparam logic [31:0] SWRS_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    SWRS_WAKE_NONE,
    SWRS_WAKE_MASTER,
    SWRS_WAKE_WDT,
    SWRS_WAKE_PIN
  } swrs_wake_t;
endpackage

// file: verilog/swrs_top.sv
`timescale 1ns/1ps
module swrs_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] instr,
  input wire logic instr_valid,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  input wire logic brown_out,
  input wire logic config_watchdog_enable,
  input wire logic [7:0] second_io_port,
  output logic osc_driver_en,
  output logic io_hold,
  output logic wdt_run,
  output logic wdt_clear,
  output logic device_reset,
  output swrs_pkg::swrs_wake_t wake_cause,
  input wire logic [swrs_pkg::SWRS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [swrs_pkg::SWRS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import swrs_pkg::*;

  function automatic logic is_mapped(input logic [SWRS_ADDR_W-1:0] a);
    is_mapped = (a == SWRS_OFS_STATUS) || (a == SWRS_OFS_CTRL);
  endfunction

  // opcode decode shared by both instructions
  function automatic logic is_op(input logic [11:0] got,
                                 input logic [11:0] code);
    is_op = (got == code);
  endfunction

  logic sleep_q;
  logic timeout_flag_n_q;
  logic powerdown_flag_n_q;
  logic pin_change_wake_flag_n_q;
  logic soft_watchdog_enable_q;
  logic pcw_enable_q;
  logic [7:0] pin_snap_q;
  logic [7:0] pin_diff;
  logic sleep_instr;
  logic clear_watchdog_instr;
  logic wdt_enabled;
  logic wdt_event;
  logic clear_pin_event;
  logic pin_event;
  logic wake;
  logic reset_event;
  logic stay_asleep;

  // software control falls back when the config bit is clear
  assign wdt_enabled = config_watchdog_enable | soft_watchdog_enable_q;
  assign sleep_instr = instr_valid && !sleep_q
                       && is_op(instr, SWRS_OP_SLEEP);
  assign clear_watchdog_instr = instr_valid && !sleep_q
                                && is_op(instr, SWRS_OP_CLEAR_WDOG);
  assign wdt_event = wdt_timeout && wdt_enabled;
  assign clear_pin_event = !master_clear_n;
  assign pin_diff = (second_io_port ^ pin_snap_q) & SWRS_WAKE_MASK;
  assign pin_event = sleep_q && pcw_enable_q && (pin_diff != 8'h00);
  assign wake = sleep_q && (clear_pin_event || wdt_event
                || pin_event || brown_out);
  // watchdog timeout and master-clear both arrive as inputs here
  assign reset_event = wake || brown_out || clear_pin_event
                       || wdt_event;
  // sleep state as it will stand after this edge
  assign stay_asleep = (sleep_q && !wake) || sleep_instr;

  // sleep state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sleep_q <= 1'b0;
    end else if (wake) begin
      sleep_q <= 1'b0;
    end else if (sleep_instr) begin
      sleep_q <= 1'b1;
    end
  end

  // pin snapshot at sleep entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_snap_q <= 8'h00;
    end else if (sleep_instr) begin
      pin_snap_q <= second_io_port;
    end
  end

  // timeout flag; a watchdog timeout beats a same-cycle set by instruction, a brown-out beats the timeout
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timeout_flag_n_q <= 1'b1;
    end else if (brown_out) begin
      timeout_flag_n_q <= 1'b1;
    end else if (wdt_event) begin
      timeout_flag_n_q <= 1'b0;
    end else if (sleep_instr || clear_watchdog_instr) begin
      timeout_flag_n_q <= 1'b1;
    end else begin
      timeout_flag_n_q <= timeout_flag_n_q;
    end
  end

  // powerdown flag; the watchdog never touches it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerdown_flag_n_q <= 1'b1;
    end else if (brown_out) begin
      powerdown_flag_n_q <= 1'b1;
    end else if (sleep_instr) begin
      powerdown_flag_n_q <= 1'b0;
    end else if (clear_watchdog_instr) begin
      powerdown_flag_n_q <= 1'b1;
    end else begin
      powerdown_flag_n_q <= powerdown_flag_n_q;
    end
  end

  // pin-change wake flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_change_wake_flag_n_q <= 1'b1;
    end else if (brown_out) begin
      pin_change_wake_flag_n_q <= 1'b1;
    end else if (pin_event) begin
      pin_change_wake_flag_n_q <= 1'b0;
    end else if (sleep_instr) begin
      pin_change_wake_flag_n_q <= 1'b1;
    end else begin
      pin_change_wake_flag_n_q <= pin_change_wake_flag_n_q;
    end
  end

  // oscillator driver is off for as long as the core sleeps
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc_driver_en <= 1'b1;
    end else begin
      osc_driver_en <= !stay_asleep;
    end
  end

  // pins keep their state while asleep
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      io_hold <= 1'b0;
    end else begin
      io_hold <= stay_asleep;
    end
  end

  // watchdog keeps running in sleep
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wdt_run <= 1'b0;
    end else begin
      wdt_run <= wdt_enabled;
    end
  end

  // counter restarts on sleep entry, its clear opcode and every wake
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= sleep_instr || clear_watchdog_instr || wake;
    end
  end

  // one pulse for each cycle that carries a reset event
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= reset_event;
    end
  end

  // cause of the last wake-up
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_cause <= SWRS_WAKE_NONE;
    end else if (wake) begin
      if (wdt_event) begin
        wake_cause <= SWRS_WAKE_WDT;
      end else if (pin_event) begin
        wake_cause <= SWRS_WAKE_PIN;
      end else if (clear_pin_event) begin
        wake_cause <= SWRS_WAKE_MASTER;
      end else begin
        wake_cause <= SWRS_WAKE_NONE;
      end
    end
  end

  // AXI4-Lite write channel
  logic aw_got_q;
  logic w_got_q;
  logic [SWRS_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_hs;
  logic w_hs;
  logic do_write;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign do_write = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (do_write) begin
      aw_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (aw_hs) begin
      aw_got_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      w_got_q <= 1'b0;
      w_data_q <= SWRS_ZERO32;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (do_write) begin
      w_got_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (w_hs) begin
      w_got_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_got_q && !s_axi_bvalid;
    end
  end

  logic [SWRS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;

  assign wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? w_data_q : s_axi_wdata;
  assign wr_lane0 = w_got_q ? w_strb_q[0] : s_axi_wstrb[0];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SWRS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_addr) ? SWRS_RESP_OKAY : SWRS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      soft_watchdog_enable_q <= SWRS_CTRL_RST[SWRS_CT_SWDT];
      pcw_enable_q <= SWRS_CTRL_RST[SWRS_CT_PCWEN];
    end else if (do_write && wr_lane0 && (wr_addr == SWRS_OFS_CTRL)) begin
      soft_watchdog_enable_q <= wr_data[SWRS_CT_SWDT];
      pcw_enable_q <= wr_data[SWRS_CT_PCWEN];
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rd_word;

  always_comb begin
    rd_word = SWRS_ZERO32;
    if (s_axi_araddr == SWRS_OFS_STATUS) begin
      rd_word[SWRS_ST_SLEEP] = sleep_q;
      rd_word[SWRS_ST_PWD] = powerdown_flag_n_q;
      rd_word[SWRS_ST_TMO] = timeout_flag_n_q;
      rd_word[SWRS_ST_PCW] = pin_change_wake_flag_n_q;
    end else if (s_axi_araddr == SWRS_OFS_CTRL) begin
      rd_word[SWRS_CT_SWDT] = soft_watchdog_enable_q;
      rd_word[SWRS_CT_PCWEN] = pcw_enable_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= SWRS_ZERO32;
      s_axi_rresp <= SWRS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? SWRS_RESP_OKAY
                                              : SWRS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// file: verif/swrs_top_assertions.sv
`timescale 1ns/1ps
module swrs_checker
  import swrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] instr,
  input wire logic instr_valid,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  input wire logic brown_out,
  input wire logic config_watchdog_enable,
  input wire logic osc_driver_en,
  input wire logic io_hold,
  input wire logic wdt_run,
  input wire logic wdt_clear,
  input wire logic device_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire go_sleep = instr_valid && instr == SWRS_OP_SLEEP && osc_driver_en &&
    master_clear_n && !brown_out && !wdt_timeout;
  sequence s_asleep;
    !osc_driver_en && io_hold;
  endsequence
  sequence s_wake;
    osc_driver_en && !io_hold && device_reset && wdt_clear;
  endsequence
  chk_sleep_entry: assert property (
    go_sleep |=> s_asleep ##0 wdt_clear) else $error("sleep entry");
  chk_sleep_only: assert property (
    $fell(osc_driver_en) |-> $past(go_sleep)) else $error("stray sleep");
  chk_master_wake: assert property (
    s_asleep ##0 !master_clear_n |=> s_wake)
    else $error("master-clear wake");
  chk_bo_wake: assert property (
    s_asleep ##0 brown_out |=> s_wake) else $error("brown-out wake");
  chk_wdt_wake: assert property (
    s_asleep ##0 (wdt_timeout && wdt_run) |=> s_wake)
    else $error("watchdog wake");
  chk_wdt_reset: assert property (
    osc_driver_en && wdt_run && wdt_timeout |=> device_reset)
    else $error("watchdog reset");
  chk_master_reset: assert property (
    !master_clear_n |=> device_reset) else $error("master-clear reset");
  chk_cfg_run: assert property (
    config_watchdog_enable |=> wdt_run) else $error("watchdog run");
endmodule

bind swrs_top swrs_checker i_swrs_checker (
  .core_clk, .sys_rst, .instr, .instr_valid, .master_clear_n,
  .wdt_timeout, .brown_out, .config_watchdog_enable, .osc_driver_en,
  .io_hold, .wdt_run, .wdt_clear, .device_reset
);

// file: verif/swrs_wdog_model.sv
`timescale 1ns/1ps
module swrs_wdog_model #(
  parameter int LIMIT = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wdt_run,
  input wire logic wdt_clear,
  output logic wdt_timeout = 1'b0
);
  int cnt_q = 0;
  // period restarts on a clear from the block or after each timeout
  always @(posedge core_clk) begin
    if (sys_rst || wdt_clear || !wdt_run || cnt_q == LIMIT - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    wdt_timeout <= !sys_rst && wdt_run && !wdt_clear && cnt_q == LIMIT - 1;
  end
endmodule

// file: verif/swrs_top_test.sv
`timescale 1ns/1ps
module swrs_top_test;
  import swrs_pkg::*;
  logic core_clk = 0, sys_rst = 1, instr_valid = 0, master_clear_n = 1;
  logic brown_out = 0, config_watchdog_enable = 0, wdt_timeout;
  logic [11:0] instr = 12'h000, op;
  logic [7:0] second_io_port = 8'h00;
  logic osc_driver_en, io_hold, wdt_run, wdt_clear, device_reset;
  swrs_wake_t wake_cause;
  swrs_wake_t tbl[4] = '{SWRS_WAKE_MASTER, SWRS_WAKE_WDT, SWRS_WAKE_PIN,
    SWRS_WAKE_NONE};
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, q;
  logic [31:0] seed = 32'h0000_0052;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int bad_count = 0, n_checks = 0, tmo = 1, pwd = 1, pcw = 1, k, b;
  swrs_top i_swrs_top (.core_clk, .sys_rst, .instr, .instr_valid,
    .master_clear_n, .wdt_timeout, .brown_out, .config_watchdog_enable,
    .second_io_port, .osc_driver_en, .io_hold, .wdt_run, .wdt_clear,
    .device_reset, .wake_cause, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  swrs_wdog_model i_swrs_wdog_model (.core_clk, .sys_rst, .wdt_run,
    .wdt_clear, .wdt_timeout);
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic lim(input int i);
    if (i == 200) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  endtask
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
    end
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    lim(i);
  endtask
  task automatic st(input int sl);
    logic [31:0] e;
    bus(0, SWRS_OFS_STATUS, SWRS_ZERO32);
    e = 32'((pcw << SWRS_ST_PCW) | (tmo << SWRS_ST_TMO) |
      (pwd << SWRS_ST_PWD) | (sl << SWRS_ST_SLEEP));
    cmp(q, e, "status");
  endtask
  task automatic ins(input logic [11:0] o);
    @(posedge core_clk);
    instr <= o;
    instr_valid <= 1;
    @(posedge core_clk);
    instr_valid <= 0;
    @(posedge core_clk);
  endtask
  task automatic wt(input bit dr);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if ((dr ? device_reset : osc_driver_en) === 1'b1) break;
    end
    lim(i);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 0;
    st(0);
    bus(1, 4'h8, 32'h0000_0003);
    cmp(32'(r), 32'(SWRS_RESP_SLVERR), "unmapped write");
    bus(0, SWRS_OFS_CTRL, SWRS_ZERO32);
    cmp(q, 32'(SWRS_CTRL_RST), "ctrl");
    bus(0, 4'h8, SWRS_ZERO32);
    cmp(32'(r), 32'(SWRS_RESP_SLVERR), "unmapped");
    $display("register test done");
    repeat (4) begin
      op = 12'(rnd());
      if (op == SWRS_OP_SLEEP) op = SWRS_OP_CLEAR_WDOG;
      ins(op);
      cmp(32'(osc_driver_en), 32'h0000_0001, "awake");
    end
    bus(1, SWRS_OFS_CTRL, 32'h0000_0003);
    cmp(32'(r), 32'(SWRS_RESP_OKAY), "bresp");
    wt(1);
    cmp(32'(wdt_run), 32'h0000_0001, "soft enable");
    tmo = 0;
    bus(1, SWRS_OFS_CTRL, 32'(SWRS_CTRL_RST));
    st(0);
    ins(SWRS_OP_CLEAR_WDOG);
    tmo = 1;
    st(0);
    $display("soft watchdog test done");
    for (k = 0; k < 4; k++) begin
      config_watchdog_enable <= (k == 1);
      second_io_port <= 8'(rnd());
      ins(SWRS_OP_SLEEP);
      tmo = 1;
      pwd = 0;
      pcw = 1;
      st(1);
      if (k == 2) begin
        ins(SWRS_OP_CLEAR_WDOG);
        second_io_port <= second_io_port ^ 8'h70;
        st(1);
        b = rnd() % 5;
        if (b == 4) b = 7;
        second_io_port <= second_io_port ^ (8'h01 << b);
      end
      master_clear_n <= (k != 0);
      brown_out <= (k == 3);
      @(posedge core_clk);
      master_clear_n <= 1;
      brown_out <= 0;
      wt(0);
      config_watchdog_enable <= 0;
      if (k == 1) tmo = 0;
      if (k == 2) pcw = 0;
      if (k == 3) begin
        tmo = 1;
        pwd = 1;
        pcw = 1;
      end
      cmp(32'(wake_cause), 32'(tbl[k]), "cause");
      st(0);
      $display("wake test %0d done", k);
    end
    end_of_test();
  end
endmodule
